// *** hdl/atf_pkg.sv ***
// Constants, types and register map of the advertising telegram framer
package atf_pkg;

    // Fixed frame fields
    localparam logic [7:0]  PREAMBLE       = 8'hAA;
    localparam logic [31:0] ACCESS_ADDR    = 32'h8E89BED6;
    localparam logic [15:0] HDR_DATA       = 16'h1342;
    localparam logic [15:0] HDR_COMM       = 16'h2442;
    localparam logic [7:0]  PAY_LEN_DATA   = 8'h0C;
    localparam logic [7:0]  PAY_LEN_COMM   = 8'h1D;
    localparam logic [7:0]  PAY_TYPE       = 8'hFF;

    // Byte positions inside a frame and payload lengths
    localparam logic [5:0]  POS_HDR        = 6'h05;
    localparam logic [5:0]  POS_PAY        = 6'h0D;
    localparam logic [5:0]  PLEN_DATA      = 6'h0D;
    localparam logic [5:0]  PLEN_COMM      = 6'h1E;
    localparam logic [5:0]  CRC_BYTES      = 6'h03;

    // Checksum of the advertising channel
    localparam logic [23:0] CRC_INIT       = 24'h555555;
    localparam logic [23:0] CRC_POLY       = 24'h00065B;

    // Channels and whitening seeds
    localparam logic [6:0]  CH_DEF0        = 7'h25;
    localparam logic [6:0]  CH_DEF1        = 7'h26;
    localparam logic [6:0]  CH_DEF2        = 7'h27;
    localparam logic [6:0]  CH_STD_MAX     = 7'h27;
    localparam logic [6:0]  CH_CUSTOM_BASE = 7'h28;
    localparam logic [6:0]  CUSTOM_MHZ_OFS = 7'h03;

    // Address type markers and random source seed
    localparam logic [1:0]  STATIC_TOP     = 2'h3;
    localparam logic [1:0]  RPA_TOP        = 2'h1;
    localparam logic [23:0] LFSR_SEED      = 24'h000001;

    // Event spacing
    localparam int unsigned CLK_PERIOD_NS      = 10;
    localparam int unsigned INTERVAL_LONG_MS   = 20;
    localparam int unsigned INTERVAL_SHORT_MS  = 10;
    localparam int unsigned INTERVAL_LONG_CYC  = INTERVAL_LONG_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned INTERVAL_SHORT_CYC = INTERVAL_SHORT_MS * 1000000 / CLK_PERIOD_NS;
    localparam logic [3:0]  MIN_EVENTS     = 4'h2;

    // Register byte offsets
    localparam logic [7:0]  REG_CTRL       = 8'h00;
    localparam logic [7:0]  REG_CHAN       = 8'h04;
    localparam logic [7:0]  REG_ADDR       = 8'h08;
    localparam logic [7:0]  REG_MANUF      = 8'h0C;
    localparam logic [7:0]  REG_SEQ        = 8'h10;
    localparam logic [7:0]  REG_STATUS     = 8'h14;
    localparam logic [7:0]  REG_SRC_LO     = 8'h18;
    localparam logic [7:0]  REG_SRC_HI     = 8'h1C;

    // Control field positions and reset values
    localparam int          CTRL_SHORT_BIT = 0;
    localparam int          CTRL_RPA_BIT   = 1;
    localparam int          CTRL_UKEY_BIT  = 2;
    localparam int          CTRL_EVT_LSB   = 4;
    localparam logic [3:0]  EVENTS_RST     = 4'h3;
    localparam int          CHAN0_LSB      = 0;
    localparam int          CHAN1_LSB      = 8;
    localparam int          CHAN2_LSB      = 16;
    localparam int          CHEN_LSB       = 24;
    localparam logic [2:0]  CHEN_RST       = 3'h7;
    localparam int          STAT_BUSY_BIT  = 0;
    localparam int          STAT_SLOT_LSB  = 4;
    localparam int          STAT_EVT_LSB   = 8;

    // Controller states
    typedef enum logic [1:0] {ST_IDLE, ST_CRYPTO, ST_FRAME, ST_GAP} atf_state_e;

    // One byte towards the radio
    typedef struct packed {
        logic [7:0] data;
        logic       first;
        logic       last;
        logic [6:0] channel;
        logic [6:0] whiten_seed;
    } atf_tx_s;

    // Request to the hash and signature engine
    typedef struct packed {
        logic         need_hash;
        logic         need_sig;
        logic [23:0]  prand;
        logic [127:0] key;
        logic [31:0]  seq;
        logic [7:0]   status;
    } atf_crypto_req_s;

    // Answer of the hash and signature engine
    typedef struct packed {
        logic [23:0] hash;
        logic [31:0] sig;
    } atf_crypto_rsp_s;

endpackage

// *** hdl/atf_framer.sv ***
// Advertising telegram framer: event scheduler, frame builder and Wishbone registers
//
// Our own choices: register access over Wishbone and the register offsets.
`timescale 1ns/100ps
module atf_framer
    import atf_pkg::*;
#(
    parameter int unsigned    LONG_CYC     = atf_pkg::INTERVAL_LONG_CYC,
    parameter int unsigned    SHORT_CYC    = atf_pkg::INTERVAL_SHORT_CYC,
    parameter logic [15:0]    DEV_TYPE     = 16'hC3A5, // Arbitrary value
    parameter logic [3:0]     TYPE_NIBBLE  = 4'h9, // Arbitrary value
    parameter logic [27:0]    ADDR_RST     = 28'h0000001,
    parameter logic [15:0]    MANUF_RST    = 16'h0F0F
) (
    // Clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    // Wishbone slave
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [7:0]                wb_adr_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic [31:0]               wb_dat_i,
    output logic      [31:0]               wb_dat_o,
    output logic                           wb_ack_o,
    // Telegram request
    input  wire logic                      tx_start_i,
    input  wire logic                      tx_commission_i,
    input  wire logic [7:0]                tx_status_i,
    output logic                           busy_o,
    // Keys held in non-volatile storage
    input  wire logic [127:0]              factory_key_i,
    input  wire logic [127:0]              user_key_i,
    // Hash and signature engine
    output logic                           crypto_req_o,
    output atf_pkg::atf_crypto_req_s       crypto_o,
    input  wire logic                      crypto_done_i,
    input  wire atf_pkg::atf_crypto_rsp_s  crypto_i,
    // Byte stream to the radio
    output logic                           tx_valid_o,
    output atf_pkg::atf_tx_s               tx_o,
    input  wire logic                      tx_ready_i
);
    import atf_pkg::*;

    // Shift one byte, LSB first, through the checksum register
    function automatic logic [23:0] crc_upd(input logic [23:0] c, input logic [7:0] b);
        logic [23:0] r;
        logic        fb;
        r = c;
        for (int i = 0; i < 8; i++) begin
            fb = r[23] ^ b[i];
            r  = {r[22:0], 1'b0};
            if (fb) begin
                r = r ^ CRC_POLY;
            end
        end
        return r;
    endfunction

    // Checksum goes out high bit first on air, so each byte is bit reversed
    function automatic logic [7:0] crc_out(input logic [23:0] c, input logic [1:0] k);
        logic [7:0] o;
        o = 8'h00;
        for (int i = 0; i < 8; i++) begin
            o[i] = c[23 - 8 * int'(k) - i];
        end
        return o;
    endfunction

    // First enabled slot at or above a start slot, with found flag on top
    function automatic logic [2:0] slot_from(input logic [2:0] mask, input logic [2:0] from);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 2; i >= 0; i--) begin
            if (mask[i] && (3'(i) >= from)) begin
                r = {1'b1, 2'(i)};
            end
        end
        return r;
    endfunction

    // Whitening seed from channel number
    function automatic logic [6:0] wseed(input logic [6:0] ch);
        logic [6:0] s;
        if (ch <= CH_STD_MAX) begin
            s = ch;
        end else begin
            s = 7'((ch - CH_CUSTOM_BASE) << 1) + CUSTOM_MHZ_OFS;
        end
        return s;
    endfunction

    // Byte-lane merge of a Wishbone write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    // Configuration and state registers
    logic                  short_r;
    logic                  rpa_r;
    logic                  ukey_r;
    logic [3:0]            events_r;
    logic [6:0]            chan_r [3];
    logic [2:0]            chen_r;
    logic [27:0]           addr_r;
    logic [15:0]           manuf_r;
    logic [31:0]           seq_r;
    logic                  ack_r;
    logic [31:0]           rd_r;
    atf_state_e            state_r;
    logic                  comm_r;
    logic [7:0]            status_r;
    logic [31:0]           sig_r;
    logic [47:0]           src_r;
    logic [23:0]           lfsr_r;
    logic [23:0]           crc_r;
    logic [5:0]            idx_r;
    logic [1:0]            slot_r;
    logic [3:0]            evt_r;
    logic [31:0]           gap_r;
    logic                  tx_valid_r;
    atf_tx_s               tx_r;
    atf_crypto_req_s       creq_r;

    // Register images for reads and byte-lane writes
    wire logic [31:0]      ctrl_img   = {24'h0, events_r, 1'b0, ukey_r, rpa_r, short_r};
    wire logic [31:0]      chan_img   = {5'h0, chen_r, 1'b0, chan_r[2], 1'b0, chan_r[1], 1'b0, chan_r[0]};
    wire logic [31:0]      addr_img   = {4'h0, addr_r};
    wire logic [31:0]      manuf_img  = {16'h0, manuf_r};
    wire logic [31:0]      status_img = {20'h0, evt_r, 2'h0, slot_r, 3'h0, busy_o};

    // Bus decode: one cycle answer for every address, unmapped reads give zero
    wire logic             wb_req     = wb_cyc_i & wb_stb_i & ~ack_r;
    wire logic             wb_wr      = wb_req & wb_we_i;
    wire logic [31:0]      ctrl_w     = merge(ctrl_img, wb_dat_i, wb_sel_i);
    wire logic [31:0]      chan_w     = merge(chan_img, wb_dat_i, wb_sel_i);
    wire logic [31:0]      addr_w     = merge(addr_img, wb_dat_i, wb_sel_i);
    wire logic [31:0]      manuf_w    = merge(manuf_img, wb_dat_i, wb_sel_i);
    wire logic [31:0]      rd_mux     = (wb_adr_i == REG_CTRL)   ? ctrl_img :
                                        (wb_adr_i == REG_CHAN)   ? chan_img :
                                        (wb_adr_i == REG_ADDR)   ? addr_img :
                                        (wb_adr_i == REG_MANUF)  ? manuf_img :
                                        (wb_adr_i == REG_SEQ)    ? seq_r :
                                        (wb_adr_i == REG_STATUS) ? status_img :
                                        (wb_adr_i == REG_SRC_LO) ? src_r[31:0] :
                                        (wb_adr_i == REG_SRC_HI) ? {16'h0, src_r[47:32]} : 32'h0;

    // Addresses: fixed type fields, configurable tail, private from random plus hash
    wire logic [47:0]      static_adr = {STATIC_TOP, DEV_TYPE[13:0], TYPE_NIBBLE, addr_r};
    wire logic [23:0]      prand      = {RPA_TOP, lfsr_r[21:0]};
    wire logic [127:0]     irk        = ukey_r ? user_key_i : factory_key_i;

    // Frame content, byte 0 in the low bits so each field leaves LSB first
    wire logic [5:0]       plen       = comm_r ? PLEN_COMM : PLEN_DATA;
    wire logic [5:0]       crc_pos    = POS_PAY + plen;
    wire logic [5:0]       flen       = crc_pos + CRC_BYTES;
    wire logic [15:0]      hdr        = comm_r ? HDR_COMM : HDR_DATA;
    wire logic [239:0]     pay_data   = {136'h0, sig_r, status_r, seq_r, manuf_r, PAY_TYPE, PAY_LEN_DATA};
    wire logic [239:0]     pay_comm   = {static_adr, creq_r.key, seq_r, manuf_r, PAY_TYPE, PAY_LEN_COMM};
    wire logic [343:0]     front      = {comm_r ? pay_comm : pay_data, src_r, hdr, ACCESS_ADDR, PREAMBLE};
    wire logic [5:0]       crc_k      = idx_r - crc_pos;
    wire logic [7:0]       cur_byte   = (idx_r < crc_pos) ? front[8 * idx_r +: 8] : crc_out(crc_r, crc_k[1:0]);
    wire logic             in_crc     = (idx_r >= POS_HDR) && (idx_r < crc_pos);

    // Channel stepping and event bookkeeping
    wire logic [2:0]       chen_eff   = (chen_r == 3'h0) ? CHEN_RST : chen_r;
    wire logic [2:0]       first_slot = slot_from(chen_eff, 3'h0);
    wire logic [2:0]       next_slot  = slot_from(chen_eff, 3'({1'b0, slot_r}) + 3'h1);
    wire logic [3:0]       events_eff = (events_r < MIN_EVENTS) ? MIN_EVENTS : events_r;
    wire logic             last_evt   = (evt_r + 4'h1) >= events_eff;
    wire logic [31:0]      gap_load   = short_r ? 32'(SHORT_CYC - 1) : 32'(LONG_CYC - 1);
    wire logic             out_free   = ~tx_valid_r | tx_ready_i;
    wire logic             frame_end  = (state_r == ST_FRAME) && out_free && (idx_r == flen);
    wire logic             start_ok   = (state_r == ST_IDLE) && tx_start_i;
    wire logic             need_hash  = rpa_r;
    wire logic             need_sig   = ~tx_commission_i;

    // Bus answer and read data, both registered
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            rd_r  <= 32'h0;
        end else begin
            ack_r <= wb_req;
            rd_r  <= rd_mux;
        end
    end

    // Configuration written by software; defaults as after production
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            short_r   <= 1'b0;
            rpa_r     <= 1'b0;
            ukey_r    <= 1'b0;
            events_r  <= EVENTS_RST;
            chan_r[0] <= CH_DEF0;
            chan_r[1] <= CH_DEF1;
            chan_r[2] <= CH_DEF2;
            chen_r    <= CHEN_RST;
            addr_r    <= ADDR_RST;
            manuf_r   <= MANUF_RST;
        end else if (wb_wr) begin
            if (wb_adr_i == REG_CTRL) begin
                short_r  <= ctrl_w[CTRL_SHORT_BIT];
                rpa_r    <= ctrl_w[CTRL_RPA_BIT];
                ukey_r   <= ctrl_w[CTRL_UKEY_BIT];
                events_r <= ctrl_w[CTRL_EVT_LSB +: 4];
            end
            if (wb_adr_i == REG_CHAN) begin
                chan_r[0] <= chan_w[CHAN0_LSB +: 7];
                chan_r[1] <= chan_w[CHAN1_LSB +: 7];
                chan_r[2] <= chan_w[CHAN2_LSB +: 7];
                chen_r    <= chan_w[CHEN_LSB +: 3];
            end
            if (wb_adr_i == REG_ADDR) begin
                addr_r <= addr_w[27:0];
            end
            if (wb_adr_i == REG_MANUF) begin
                manuf_r <= manuf_w[15:0];
            end
        end
    end

    // Free running random source for the private address
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lfsr_r <= LFSR_SEED;
        end else begin
            lfsr_r <= {lfsr_r[22:0], lfsr_r[23] ^ lfsr_r[22] ^ lfsr_r[21] ^ lfsr_r[16]};
        end
    end

    // Sequence counter: counts whole telegrams, not events or frames
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seq_r <= 32'h0;
        end else if (frame_end && !next_slot[2] && last_evt) begin
            seq_r <= seq_r + 32'h1;
        end
    end

    // Telegram capture and engine request; hash and signature are external
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            comm_r   <= 1'b0;
            status_r <= 8'h00;
            creq_r   <= '0;
        end else if (start_ok) begin
            comm_r           <= tx_commission_i;
            status_r         <= tx_status_i;
            creq_r.need_hash <= need_hash;
            creq_r.need_sig  <= need_sig;
            creq_r.prand     <= prand;
            creq_r.key       <= irk;
            creq_r.seq       <= seq_r;
            creq_r.status    <= tx_status_i;
        end
    end

    // Source address and signature, fixed for all events of one telegram
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            src_r <= 48'h0;
            sig_r <= 32'h0;
        end else if (start_ok && !need_hash) begin
            src_r <= static_adr;
        end else if ((state_r == ST_CRYPTO) && crypto_done_i) begin
            if (creq_r.need_hash) begin
                src_r <= {creq_r.prand, crypto_i.hash};
            end
            if (creq_r.need_sig) begin
                sig_r <= crypto_i.sig;
            end
        end
    end

    // Sequencer: engine wait, frames on each enabled slot, gaps between events
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            slot_r  <= 2'h0;
            evt_r   <= 4'h0;
            gap_r   <= 32'h0;
            idx_r   <= 6'h0;
            crc_r   <= CRC_INIT;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (tx_start_i) begin
                        evt_r  <= 4'h0;
                        slot_r <= first_slot[1:0];
                        idx_r  <= 6'h0;
                        crc_r  <= CRC_INIT;
                        if (need_hash || need_sig) begin
                            state_r <= ST_CRYPTO;
                        end else begin
                            state_r <= ST_FRAME;
                        end
                    end
                end
                ST_CRYPTO: begin
                    if (crypto_done_i) begin
                        state_r <= ST_FRAME;
                    end
                end
                ST_FRAME: begin
                    if (out_free && (idx_r != flen)) begin
                        idx_r <= idx_r + 6'h1;
                        if (in_crc) begin
                            crc_r <= crc_upd(crc_r, cur_byte);
                        end
                    end else if (frame_end) begin
                        idx_r <= 6'h0;
                        crc_r <= CRC_INIT;
                        if (next_slot[2]) begin
                            slot_r <= next_slot[1:0];
                        end else if (last_evt) begin
                            state_r <= ST_IDLE;
                        end else begin
                            evt_r   <= evt_r + 4'h1;
                            gap_r   <= gap_load;
                            state_r <= ST_GAP;
                        end
                    end
                end
                ST_GAP: begin
                    if (gap_r == 32'h0) begin
                        slot_r  <= first_slot[1:0];
                        state_r <= ST_FRAME;
                    end else begin
                        gap_r <= gap_r - 32'h1;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Output stage: a byte stands until the radio takes it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_valid_r <= 1'b0;
            tx_r       <= '0;
        end else if (out_free) begin
            if ((state_r == ST_FRAME) && (idx_r != flen)) begin
                tx_valid_r       <= 1'b1;
                tx_r.data        <= cur_byte;
                tx_r.first       <= (idx_r == 6'h0);
                tx_r.last        <= (idx_r == flen - 6'h1);
                tx_r.channel     <= chan_r[slot_r];
                tx_r.whiten_seed <= wseed(chan_r[slot_r]);
            end else begin
                tx_valid_r <= 1'b0;
            end
        end
    end

    // Outputs
    assign wb_ack_o     = ack_r;
    assign wb_dat_o     = rd_r;
    assign busy_o       = (state_r != ST_IDLE);
    assign crypto_req_o = (state_r == ST_CRYPTO);
    assign crypto_o     = creq_r;
    assign tx_valid_o   = tx_valid_r;
    assign tx_o         = tx_r;

endmodule

// *** tb/atf_framer_assertions.sv ***
// Port checker of the telegram framer
`timescale 1ns/100ps
module atf_framer_chk
    import atf_pkg::*;
(
    // Clock, bus and request
    input wire logic            clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_ack_o,
    input wire logic            tx_start_i, busy_o, crypto_req_o, crypto_done_i,
    // Radio side and engine request
    input wire logic            tx_valid_o, tx_ready_i,
    input wire atf_tx_s         tx_o,
    input wire atf_crypto_req_s crypto_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Bus answers in one cycle and never stretches the ack
    chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    chk_busy_take: assert property (tx_start_i && !busy_o |=> busy_o) else $error("start lost");
    chk_pre_first: assert property (tx_valid_o && tx_o.first |-> tx_o.data == 8'hAA) else $error("bad preamble");
    chk_access_lsb: assert property (tx_valid_o && tx_ready_i && tx_o.first |=> tx_valid_o && tx_o.data == 8'hD6)
        else $error("bad access byte");
    // Radio stall must not lose or alter a byte
    chk_byte_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_o))
        else $error("byte dropped");
    chk_frame_gap: assert property (tx_valid_o && tx_ready_i && tx_o.last |=> !tx_valid_o) else $error("no gap");
    chk_seed_std: assert property (tx_valid_o && tx_o.channel < 7'h28 |-> tx_o.whiten_seed == tx_o.channel)
        else $error("bad seed");
    // Custom channels seed with their offset above 2400 MHz
    chk_seed_cust: assert property (tx_valid_o && tx_o.channel > 7'h27 |->
        tx_o.whiten_seed == 7'(2 * (tx_o.channel - 7'h28) + 3)) else $error("bad custom seed");
    chk_prand_top: assert property (crypto_req_o && crypto_o.need_hash |-> crypto_o.prand[23:22] == 2'h1)
        else $error("bad prand");
    chk_req_hold: assert property (crypto_req_o && !crypto_done_i |=> crypto_req_o && $stable(crypto_o))
        else $error("request moved");
    // Main scenarios reached
    cov_frame: cover property (tx_valid_o && tx_ready_i && tx_o.last);
    cov_hash: cover property (crypto_req_o && crypto_o.need_hash);
    cov_refused: cover property (busy_o && tx_start_i);
endmodule

// *** tb/atf_radio.sv ***
// Radio receiver model collecting frames byte by byte
`timescale 1ns/100ps
module atf_radio
    import atf_pkg::*;
(
    input  wire logic    clk_i,
    input  wire logic    slow_i,
    input  wire logic    tx_valid_i,
    input  wire atf_tx_s tx_i,
    output logic         tx_ready_o
);
    logic [7:0] bytes_q[$];
    logic [6:0] ch_q[$];
    int         len_q[$], t_q[$];
    int         cyc = 0, n = 0;
    // Slow mode refuses every third cycle so the framer must hold
    assign tx_ready_o = !slow_i || (cyc % 3 != 0);
    // Bytes count only at the handshake edge
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (tx_valid_i && tx_ready_o) begin
            bytes_q.push_back(tx_i.data);
            if (tx_i.first) begin
                ch_q.push_back(tx_i.channel);
                t_q.push_back(cyc);
                n = 0;
            end
            n = n + 1;
            if (tx_i.last)
                len_q.push_back(n);
        end
    end
endmodule

// *** tb/atf_framer_bench.sv ***
// Self-checking bench of the advertising telegram framer
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin miscompares++; \
    $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module atf_framer_bench;
    import atf_pkg::*;
    localparam logic [127:0]    FKEY = {16{8'hA1}}, UKEY = {16{8'hB2}};
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, tx_start_i = 0, tx_commission_i = 0;
    logic slow = 0, crypto_done_i = 0, wb_ack_o, busy_o, crypto_req_o, tx_valid_o, tx_ready_i;
    logic [7:0] wb_adr_i = 8'h00, tx_status_i = 8'h05;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    atf_crypto_req_s crypto_o, req_seen;
    atf_tx_s tx_o;
    int miscompares = 0, tests_run = 0, ticks = 0, ccnt = 0;
    atf_framer #(.LONG_CYC(40), .SHORT_CYC(20)) atf_framer_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .tx_start_i, .tx_commission_i, .tx_status_i, .busy_o,
        .factory_key_i(FKEY), .user_key_i(UKEY), .crypto_req_o, .crypto_o, .crypto_done_i,
        .crypto_i({crypto_o.prand ^ crypto_o.key[23:0], 32'h11223344}), .tx_valid_o, .tx_o, .tx_ready_i);
    atf_radio atf_radio_inst (.clk_i, .slow_i(slow), .tx_valid_i(tx_valid_o), .tx_i(tx_o), .tx_ready_o(tx_ready_i));
    always #5 clk_i = ~clk_i;
    // Engine answers after a few cycles; its hash is prand xor the key's low bits so a receiver can resolve it
    always @(posedge clk_i) begin
        ticks <= ticks + 1;
        if (ticks == 5000) begin
            miscompares++;
            give_verdict();
        end
        crypto_done_i <= 0;
        if (crypto_req_o && !crypto_done_i) begin
            ccnt <= (ccnt == 3) ? 0 : ccnt + 1;
            crypto_done_i <= (ccnt == 3);
            req_seen <= crypto_o;
        end
    end
    // Classic single cycle; hold until ack is sampled
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
    endtask
    // One telegram, with a second start while busy that must be ignored
    task send(input logic comm);
        atf_radio_inst.bytes_q.delete();
        atf_radio_inst.ch_q.delete();
        atf_radio_inst.len_q.delete();
        atf_radio_inst.t_q.delete();
        @(posedge clk_i);
        {tx_start_i, tx_commission_i} <= {1'b1, comm};
        @(posedge clk_i);
        tx_start_i <= 0;
        repeat (50) @(posedge clk_i);
        tx_start_i <= 1;
        @(posedge clk_i);
        tx_start_i <= 0;
        do @(posedge clk_i); while (busy_o !== 1'b0);
    endtask
    task automatic t_reset();
        logic [7:0]  ra[6] = '{REG_CTRL, REG_CHAN, REG_SEQ, 8'h20, REG_SRC_LO, REG_SRC_HI};
        logic [31:0] re[6] = '{32'h30, 32'h07272625, 32'h0, 32'h0, 32'h0, 32'h0};
        wb(1, REG_SEQ, 32'hFFFFFFFF);
        wb(1, 8'h20, 32'hFFFFFFFF);
        for (int i = 0; i < 6; i++) begin
            wb(0, ra[i], 32'h0);
            `CHK("reg", re[i], rd)
        end
        $display("t_reset done");
    endtask
    task automatic t_data();
        logic [0:25][7:0] dx = 208'hAAD6BE898E421301000090A5C30CFF0F0F000000000544332211;
        slow <= 1;
        send(0);
        `CHK("frames", 9, atf_radio_inst.len_q.size())
        for (int f = 0; f < 9; f++) begin
            `CHK("len", 29, atf_radio_inst.len_q[f])
            `CHK("chan", 37 + f % 3, atf_radio_inst.ch_q[f])
            for (int k = 0; k < 26; k++) `CHK("byte", dx[k], atf_radio_inst.bytes_q[f * 29 + k])
        end
        `CHK("gap", 1'b1, atf_radio_inst.t_q[3] - atf_radio_inst.t_q[2] >= 69)
        `CHK("hash", 1'b0, req_seen.need_hash)
        `CHK("key", FKEY, req_seen.key)
        wb(0, REG_SEQ, 32'h0);
        `CHK("seq", 32'h1, rd)
        wb(0, REG_SRC_HI, 32'h0);
        `CHK("src", 32'hC3A5, rd)
        $display("t_data done");
    endtask
    task automatic t_comm();
        int d, id;
        logic [23:0] pr, hs;
        wb(1, REG_CTRL, 32'h7);
        wb(1, REG_CHAN, 32'h05292625);
        slow <= 0;
        send(1);
        d = atf_radio_inst.t_q[2] - atf_radio_inst.t_q[1];
        `CHK("frames", 4, atf_radio_inst.len_q.size())
        for (int f = 0; f < 4; f++) begin
            `CHK("len", 46, atf_radio_inst.len_q[f])
            `CHK("chan", (f % 2) ? 41 : 37, atf_radio_inst.ch_q[f])
        end
        `CHK("gap", 1'b1, d >= 66 && d < 86)
        `CHK("hdr", 16'h2442, {atf_radio_inst.bytes_q[6], atf_radio_inst.bytes_q[5]})
        pr = {atf_radio_inst.bytes_q[12], atf_radio_inst.bytes_q[11], atf_radio_inst.bytes_q[10]};
        hs = {atf_radio_inst.bytes_q[9], atf_radio_inst.bytes_q[8], atf_radio_inst.bytes_q[7]};
        // Receiver tries its stored keys in turn against the received hash
        id = (hs == (pr ^ FKEY[23:0])) ? 1 : (hs == (pr ^ UKEY[23:0])) ? 2 : 0;
        `CHK("hash", pr ^ UKEY[23:0], hs)
        `CHK("resolve", 2, id)
        `CHK("top", 2'h1, atf_radio_inst.bytes_q[12][7:6])
        `CHK("seq", 8'h01, atf_radio_inst.bytes_q[17])
        `CHK("irk", 8'hB2, atf_radio_inst.bytes_q[21])
        `CHK("key", UKEY, req_seen.key)
        $display("t_comm done");
    endtask
    task give_verdict();
        $display("tests_run %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 0;
        t_reset();
        t_data();
        t_comm();
        give_verdict();
    end
endmodule
bind atf_framer atf_framer_chk atf_framer_chk_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .tx_start_i,
    .busy_o, .crypto_req_o, .crypto_done_i, .tx_valid_o, .tx_ready_i, .tx_o, .crypto_o);
